// ---- rtl/fdt_pkg.sv ----
package fdt_pkg;

  localparam int unsigned CH_NUM      = 4;
  localparam int unsigned SAMPLE_W    = 14;
  localparam int unsigned MAG_W       = 13;
  localparam int unsigned DWELL_W     = 16;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned OUT_W       = 16;
  localparam int unsigned CBC_W       = 2;

  // Converter pipeline latency in sample clocks, applied to the lower
  // comparison and to the sample and overrange outputs.
  localparam int unsigned PIPE_LAT    = 8;

  // Full scale magnitude is 2**13 - 1; the largest code the magnitude holds.
  localparam logic [MAG_W-1:0] MAG_MAX = 13'h1fff;

  localparam logic [ADDR_W-1:0] FLAG_STATUS_OFS = 12'h040;
  localparam logic [ADDR_W-1:0] UPPER_LOW_OFS   = 12'h247;
  localparam logic [ADDR_W-1:0] UPPER_HIGH_OFS  = 12'h248;
  localparam logic [ADDR_W-1:0] LOWER_LOW_OFS   = 12'h249;
  localparam logic [ADDR_W-1:0] LOWER_HIGH_OFS  = 12'h24a;
  localparam logic [ADDR_W-1:0] DWELL_LOW_OFS   = 12'h24b;
  localparam logic [ADDR_W-1:0] DWELL_HIGH_OFS  = 12'h24c;

  localparam logic [DATA_W-1:0] UPPER_LOW_RST   = 8'hff;
  localparam logic [DATA_W-1:0] UPPER_HIGH_RST  = 8'h1f;
  localparam logic [DATA_W-1:0] LOWER_LOW_RST   = 8'h00;
  localparam logic [DATA_W-1:0] LOWER_HIGH_RST  = 8'h00;
  localparam logic [DATA_W-1:0] DWELL_LOW_RST   = 8'h01;
  localparam logic [DATA_W-1:0] DWELL_HIGH_RST  = 8'h00;

  // Only the low five bits of a threshold high byte are implemented.
  localparam logic [DATA_W-1:0] THR_HIGH_MASK   = 8'h1f;

endpackage

// ---- rtl/fdt_fast_detect.sv ----
`timescale 1ns/10ps

module fdt_fast_detect
  import fdt_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic [SAMPLE_W-1:0]  sampleA,
  input  wire logic [SAMPLE_W-1:0]  sampleB,
  input  wire logic [SAMPLE_W-1:0]  sampleC,
  input  wire logic [SAMPLE_W-1:0]  sampleD,
  input  wire logic [CH_NUM-1:0]    overrangeIn,
  input  wire logic [CBC_W-1:0]     controlBitCount,
  input  wire logic                 regWrEn,
  input  wire logic                 regRdEn,
  input  wire logic [ADDR_W-1:0]    regAddr,
  input  wire logic [DATA_W-1:0]    regWrData,
  output logic      [DATA_W-1:0]    regRdData,
  output logic      [OUT_W-1:0]     dataOutA,
  output logic      [OUT_W-1:0]     dataOutB,
  output logic      [OUT_W-1:0]     dataOutC,
  output logic      [OUT_W-1:0]     dataOutD,
  output logic      [CH_NUM-1:0]    overrangeOut,
  output logic                      threshold_flag_pin_a,
  output logic                      threshold_flag_pin_b,
  output logic                      threshold_flag_pin_c,
  output logic                      threshold_flag_pin_d
);

  logic [DATA_W-1:0]   upperLow_reg,  upperLow_next;
  logic [DATA_W-1:0]   upperHigh_reg, upperHigh_next;
  logic [DATA_W-1:0]   lowerLow_reg,  lowerLow_next;
  logic [DATA_W-1:0]   lowerHigh_reg, lowerHigh_next;
  logic [DATA_W-1:0]   dwellLow_reg,  dwellLow_next;
  logic [DATA_W-1:0]   dwellHigh_reg, dwellHigh_next;
  logic [DATA_W-1:0]   rdData_reg,    rdData_next;
  logic [MAG_W-1:0]    upperThr;
  logic [MAG_W-1:0]    lowerThr;
  logic [DWELL_W-1:0]  dwellTime;
  logic [SAMPLE_W-1:0] sampleIn [CH_NUM];
  logic [OUT_W-1:0]    dataOutVec [CH_NUM];
  logic [CH_NUM-1:0]   flagVec;
  logic [CH_NUM-1:0]   orVec;
  logic                wrUpperLow;
  logic                wrUpperHigh;
  logic                wrLowerLow;
  logic                wrLowerHigh;
  logic                wrDwellLow;
  logic                wrDwellHigh;

  assign sampleIn[0] = sampleA;
  assign sampleIn[1] = sampleB;
  assign sampleIn[2] = sampleC;
  assign sampleIn[3] = sampleD;

  // Multi-byte values are assembled low byte first.
  assign upperThr  = {upperHigh_reg[MAG_W-DATA_W-1:0], upperLow_reg};
  assign lowerThr  = {lowerHigh_reg[MAG_W-DATA_W-1:0], lowerLow_reg};
  assign dwellTime = {dwellHigh_reg, dwellLow_reg};

  // Write decode. The status register and unmapped offsets match no
  // strobe, so writes to them are dropped.
  assign wrUpperLow  = regWrEn && (regAddr == UPPER_LOW_OFS);
  assign wrUpperHigh = regWrEn && (regAddr == UPPER_HIGH_OFS);
  assign wrLowerLow  = regWrEn && (regAddr == LOWER_LOW_OFS);
  assign wrLowerHigh = regWrEn && (regAddr == LOWER_HIGH_OFS);
  assign wrDwellLow  = regWrEn && (regAddr == DWELL_LOW_OFS);
  assign wrDwellHigh = regWrEn && (regAddr == DWELL_HIGH_OFS);

  // Each byte takes effect on its own. Software that moves a value
  // across a byte boundary sees a mixed value for one write.
  always_comb begin
    upperLow_next  = upperLow_reg;
    upperHigh_next = upperHigh_reg;
    lowerLow_next  = lowerLow_reg;
    lowerHigh_next = lowerHigh_reg;
    dwellLow_next  = dwellLow_reg;
    dwellHigh_next = dwellHigh_reg;
    if (wrUpperLow) begin
      upperLow_next = regWrData;
    end
    if (wrUpperHigh) begin
      upperHigh_next = regWrData & THR_HIGH_MASK;
    end
    if (wrLowerLow) begin
      lowerLow_next = regWrData;
    end
    if (wrLowerHigh) begin
      lowerHigh_next = regWrData & THR_HIGH_MASK;
    end
    if (wrDwellLow) begin
      dwellLow_next = regWrData;
    end
    if (wrDwellHigh) begin
      dwellHigh_next = regWrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      upperLow_reg  <= UPPER_LOW_RST;
      upperHigh_reg <= UPPER_HIGH_RST;
      lowerLow_reg  <= LOWER_LOW_RST;
      lowerHigh_reg <= LOWER_HIGH_RST;
      dwellLow_reg  <= DWELL_LOW_RST;
      dwellHigh_reg <= DWELL_HIGH_RST;
    end else begin
      upperLow_reg  <= upperLow_next;
      upperHigh_reg <= upperHigh_next;
      lowerLow_reg  <= lowerLow_next;
      lowerHigh_reg <= lowerHigh_next;
      dwellLow_reg  <= dwellLow_next;
      dwellHigh_reg <= dwellHigh_next;
    end
  end

  // A read in the same cycle as a write returns the old value, and the
  // read data holds until the next read.
  always_comb begin
    rdData_next = rdData_reg;
    if (regRdEn) begin
      unique case (regAddr)
        FLAG_STATUS_OFS: rdData_next = {{(DATA_W-CH_NUM){1'b0}}, flagVec};
        UPPER_LOW_OFS:   rdData_next = upperLow_reg;
        UPPER_HIGH_OFS:  rdData_next = upperHigh_reg;
        LOWER_LOW_OFS:   rdData_next = lowerLow_reg;
        LOWER_HIGH_OFS:  rdData_next = lowerHigh_reg;
        DWELL_LOW_OFS:   rdData_next = dwellLow_reg;
        DWELL_HIGH_OFS:  rdData_next = dwellHigh_reg;
        default:         rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // One independent detector per converter channel. Each channel keeps
  // its own flip-flops so that no register has more than one driver.
  genvar ch;
  generate
    for (ch = 0; ch < CH_NUM; ch++) begin : gChan
      logic [SAMPLE_W-1:0] absVal;
      logic [MAG_W-1:0]    magNow;
      logic [MAG_W-1:0]    magDly_reg  [PIPE_LAT];
      logic [MAG_W-1:0]    magDly_next [PIPE_LAT];
      logic [SAMPLE_W-1:0] smpDly_reg  [PIPE_LAT];
      logic [SAMPLE_W-1:0] smpDly_next [PIPE_LAT];
      logic [PIPE_LAT-1:0] orDly_reg;
      logic [PIPE_LAT-1:0] orDly_next;
      logic [DWELL_W-1:0]  dwell_reg;
      logic [DWELL_W-1:0]  dwell_next;
      logic                flag_reg;
      logic                flag_next;
      logic                orBit_reg;
      logic                orBit_next;
      logic [OUT_W-1:0]    dataOut_reg;
      logic [OUT_W-1:0]    dataOut_next;
      logic                aboveUpper;
      logic                belowLower;
      logic                dwellDone;
      logic                ctrlBit;

      // Negative full scale would need 14 bits, so it saturates.
      always_comb begin
        if (sampleIn[ch][SAMPLE_W-1]) begin
          absVal = SAMPLE_W'(-sampleIn[ch]);
        end else begin
          absVal = sampleIn[ch];
        end
        if (absVal[SAMPLE_W-1]) begin
          magNow = MAG_MAX;
        end else begin
          magNow = absVal[MAG_W-1:0];
        end
      end

      // Sample, magnitude and overrange each run through their own delay line
      // of PIPE_LAT stages, so they cannot drift apart from each other.
      always_comb begin
        magDly_next[0] = magNow;
        smpDly_next[0] = sampleIn[ch];
        for (int i = 1; i < PIPE_LAT; i++) begin
          magDly_next[i] = magDly_reg[i-1];
          smpDly_next[i] = smpDly_reg[i-1];
        end
        orDly_next = {orDly_reg[PIPE_LAT-2:0], overrangeIn[ch]};
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          for (int i = 0; i < PIPE_LAT; i++) begin
            magDly_reg[i] <= '0;
            smpDly_reg[i] <= '0;
          end
          orDly_reg <= '0;
        end else begin
          magDly_reg <= magDly_next;
          smpDly_reg <= smpDly_next;
          orDly_reg  <= orDly_next;
        end
      end

      // Lower compare sees the pipeline delayed magnitude.
      assign belowLower = magDly_reg[PIPE_LAT-1] < lowerThr;
      assign dwellDone  = dwell_reg >= dwellTime;

      // The counter saturates rather than wrap, so a very long quiet
      // stretch can never look like a fresh short one.
      always_comb begin
        if (!belowLower) begin
          dwell_next = '0;
        end else if (dwell_reg == {DWELL_W{1'b1}}) begin
          dwell_next = dwell_reg;
        end else begin
          dwell_next = dwell_reg + 16'h0001;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          dwell_reg <= '0;
        end else begin
          dwell_reg <= dwell_next;
        end
      end

      // The upper compare uses the undelayed magnitude, so the flag rises
      // one clock after the sample, well inside the latency budget.
      assign aboveUpper = magNow > upperThr;

      // Set takes priority over clear in the same cycle.
      always_comb begin
        if (aboveUpper) begin
          flag_next = 1'b1;
        end else if (belowLower && dwellDone) begin
          flag_next = 1'b0;
        end else begin
          flag_next = flag_reg;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          flag_reg <= 1'b0;
        end else begin
          flag_reg <= flag_next;
        end
      end

      assign ctrlBit = (controlBitCount != 2'h0) & orDly_reg[PIPE_LAT-1];

      // Tail bit 1 carries the overrange control bit when enabled; bit 0 is always zero.
      always_comb begin
        orBit_next   = orDly_reg[PIPE_LAT-1];
        dataOut_next = {smpDly_reg[PIPE_LAT-1], ctrlBit, 1'b0};
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          orBit_reg   <= 1'b0;
          dataOut_reg <= '0;
        end else begin
          orBit_reg   <= orBit_next;
          dataOut_reg <= dataOut_next;
        end
      end

      assign flagVec[ch]    = flag_reg;
      assign orVec[ch]      = orBit_reg;
      assign dataOutVec[ch] = dataOut_reg;
    end
  endgenerate

  assign regRdData            = rdData_reg;
  assign overrangeOut         = orVec;
  assign dataOutA             = dataOutVec[0];
  assign dataOutB             = dataOutVec[1];
  assign dataOutC             = dataOutVec[2];
  assign dataOutD             = dataOutVec[3];
  assign threshold_flag_pin_a = flagVec[0];
  assign threshold_flag_pin_b = flagVec[1];
  assign threshold_flag_pin_c = flagVec[2];
  assign threshold_flag_pin_d = flagVec[3];

endmodule

// ---- verif/fdt_fast_detect_properties.sv ----
`timescale 1ns/10ps
module fdt_fast_detect_properties
  import fdt_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  input wire logic [SAMPLE_W-1:0] sampleA,
  input wire logic [SAMPLE_W-1:0] sampleB,
  input wire logic [SAMPLE_W-1:0] sampleC,
  input wire logic [SAMPLE_W-1:0] sampleD,
  input wire logic [CH_NUM-1:0]   overrangeIn,
  input wire logic                regRdEn,
  input wire logic [ADDR_W-1:0]   regAddr,
  input wire logic [DATA_W-1:0]   regRdData,
  input wire logic [OUT_W-1:0]    dataOutA,
  input wire logic [OUT_W-1:0]    dataOutB,
  input wire logic [OUT_W-1:0]    dataOutC,
  input wire logic [OUT_W-1:0]    dataOutD,
  input wire logic [CH_NUM-1:0]   overrangeOut,
  input wire logic                threshold_flag_pin_a,
  input wire logic                threshold_flag_pin_b,
  input wire logic                threshold_flag_pin_c,
  input wire logic                threshold_flag_pin_d
);
  logic [3:0] age;
  wire  [3:0] flags = {threshold_flag_pin_d, threshold_flag_pin_c,
                       threshold_flag_pin_b, threshold_flag_pin_a};
  // The delay line still holds reset zeros for nine edges after release.
  always_ff @(posedge sys_clk) begin
    age <= sys_rst ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_reset_clears: assert property (disable iff (1'b0) sys_rst |=>
    flags == 4'h0 && regRdData == 8'h00 && overrangeOut == 4'h0)
    else $error("outputs not cleared by reset");
  a_ovr_aligned: assert property (
    age > 4'h9 |-> overrangeOut == $past(overrangeIn, 9))
    else $error("overrange out of step with its sample");
  a_data_aligned: assert property (
    age > 4'h9 |-> dataOutA[15:2] == $past(sampleA, 9))
    else $error("sample output delay wrong");
  a_data_b_aligned: assert property (
    age > 4'h9 |-> dataOutB[15:2] == $past(sampleB, 9))
    else $error("channel B sample output delay wrong");
  a_data_c_aligned: assert property (
    age > 4'h9 |-> dataOutC[15:2] == $past(sampleC, 9))
    else $error("channel C sample output delay wrong");
  a_data_d_aligned: assert property (
    age > 4'h9 |-> dataOutD[15:2] == $past(sampleD, 9))
    else $error("channel D sample output delay wrong");
  a_ctrl_bit_b: assert property (dataOutB[1] |-> overrangeOut[1])
    else $error("channel B control bit without overrange");
  a_ctrl_bit: assert property (dataOutA[1] |-> overrangeOut[0])
    else $error("control bit without overrange");
  a_status_read: assert property (
    regRdEn && regAddr == 12'h040 |=> regRdData == {4'h0, $past(flags)})
    else $error("status read does not match flag pins");
  a_unmapped_zero: assert property (
    regRdEn && regAddr > 12'h24c |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data changed without a read");
  a_flag_cause: assert property (
    $rose(threshold_flag_pin_a) |-> $past(sampleA) != 14'h0000)
    else $error("flag rose after a zero sample");
  c_flag_rise: cover property ($rose(threshold_flag_pin_a));
  c_flag_fall: cover property ($fell(threshold_flag_pin_a));
  c_ctrl_bit: cover property (dataOutA[1]);
endmodule
bind fdt_fast_detect fdt_fast_detect_properties chk (.*);

// ---- verif/fdt_agc_host.sv ----
`timescale 1ns/10ps
// Gain loop stand-in: backs the gain off while any flag is up, and needs
// no smoothing of its own because the flags already carry hysteresis.
module fdt_agc_host (
  input  wire logic       sys_clk,
  input  wire logic [3:0] flagPins,
  output logic            gainCut
);
  always_ff @(posedge sys_clk) begin
    gainCut <= |flagPins;
  end
endmodule

// ---- verif/fdt_fast_detect_tb.sv ----
`timescale 1ns/10ps
module fdt_fast_detect_tb
  import fdt_pkg::*;
;
  logic                sys_clk, sys_rst, regWrEn, regRdEn, rdPend, gainCut;
  logic [SAMPLE_W-1:0] smp[4];
  logic [CH_NUM-1:0]   overrangeIn, overrangeOut, flagPins, expF;
  logic [CBC_W-1:0]    controlBitCount;
  logic [ADDR_W-1:0]   regAddr;
  logic [DATA_W-1:0]   regWrData, regRdData;
  logic [19:0]         expQ[$];
  int                  fails, numChecks;
  int                  seed = 41021;
  fdt_fast_detect uut (.sys_clk, .sys_rst, .sampleA(smp[0]),
    .sampleB(smp[1]), .sampleC(smp[2]), .sampleD(smp[3]), .overrangeIn,
    .controlBitCount, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .dataOutA(), .dataOutB(), .dataOutC(), .dataOutD(), .overrangeOut,
    .threshold_flag_pin_a(flagPins[0]), .threshold_flag_pin_b(flagPins[1]),
    .threshold_flag_pin_c(flagPins[2]), .threshold_flag_pin_d(flagPins[3]));
  fdt_agc_host host (.sys_clk, .flagPins, .gainCut);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic wrap_up();
    $display("checks %0d fails %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [11:0] a, input logic [7:0] got, exp);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("Error reg %h expected %h seen %h", a, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk) regWrEn = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic wr16(input logic [11:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 12'h001, v[15:8]);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    regAddr = a;
    regRdEn = 1'b1;
    expQ.push_back({a, e});
    @(negedge sys_clk) regRdEn = 1'b0;
    @(negedge sys_clk);
  endtask
  // Random magnitudes of 11..100 neither cross upper 100 nor fall below 10.
  task automatic fill(input bit r, input logic [13:0] v);
    foreach (smp[j]) smp[j] = r ? 14'(11 + $unsigned($random(seed)) % 90) : v;
  endtask
  always @(posedge sys_clk) rdPend <= regRdEn;
  always @(negedge sys_clk) begin
    overrangeIn <= 4'($random(seed));
    controlBitCount <= 2'($random(seed));
    if (rdPend === 1'b1) begin
      chk(expQ[0][19:8], regRdData, expQ[0][7:0]);
      void'(expQ.pop_front());
    end
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    logic [7:0] rv[6];
    rv = '{UPPER_LOW_RST, UPPER_HIGH_RST, LOWER_LOW_RST, LOWER_HIGH_RST,
           DWELL_LOW_RST, DWELL_HIGH_RST};
    {sys_rst, regWrEn, regRdEn, regAddr, regWrData} = {3'b100, 20'h0};
    {overrangeIn, controlBitCount, expF} = 10'h000;
    fill(1'b0, 14'h0000);
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    foreach (rv[i]) rd(12'(12'h247 + i), rv[i]);
    rd(12'h300, 8'h00);
    wr(FLAG_STATUS_OFS, 8'hff);
    rd(FLAG_STATUS_OFS, 8'h00);
    wr(UPPER_HIGH_OFS, 8'hff);
    rd(UPPER_HIGH_OFS, 8'h1f);
    wr16(UPPER_LOW_OFS, 16'h0064);
    wr16(LOWER_LOW_OFS, 16'h000a);
    wr16(DWELL_LOW_OFS, 16'h0002);
    rd(DWELL_LOW_OFS, 8'h02);
    rd(LOWER_LOW_OFS, 8'h0a);
    fill(1'b1, 14'h0000);
    repeat (12) @(negedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      smp[i] = i[0] ? 14'h3f9b : 14'h0065;
      expF[i] = 1'b1;
      @(negedge sys_clk);
      fill(1'b1, 14'h0000);
      rd(FLAG_STATUS_OFS, {4'h0, expF});
    end
    // Runs of two below-lower samples are one short of dwell 2.
    repeat (4) begin
      fill(1'b0, 14'h0000);
      repeat (2) @(negedge sys_clk);
      fill(1'b1, 14'h0000);
      @(negedge sys_clk);
    end
    repeat (12) @(negedge sys_clk);
    rd(FLAG_STATUS_OFS, 8'h0f);
    fill(1'b0, 14'h0000);
    repeat (14) @(negedge sys_clk);
    rd(FLAG_STATUS_OFS, 8'h00);
    wr16(UPPER_LOW_OFS, 16'h1fff);
    smp[0] = 14'h2000;
    rd(FLAG_STATUS_OFS, 8'h00);
    wr16(UPPER_LOW_OFS, 16'h1ffe);
    rd(FLAG_STATUS_OFS, 8'h01);
    wrap_up();
  end
endmodule
